// >>> verilog/rroe_pkg.sv
package rroe_pkg;

	// Instruction classes handled by this executor
	typedef enum logic [2:0] {
		idle_op,
		return_from_interrupt_op,
		return_with_literal_op,
		subroutine_exit_op,
		rotate_left_carry_op
	} rroe_op_t;

	// Execution phase of the current instruction
	typedef enum logic {
		ST_READY,
		ST_SECOND
	} rroe_state_t;

	// Default widths
	localparam int PC_WIDTH = 13;
	localparam int DATA_WIDTH = 8;
	localparam int FADDR_WIDTH = 7;

	// Bit position of global_interrupt_enable in interrupt_control_register
	localparam int GIE_BIT = 7;

	// Destination select encodings for rotate
	localparam logic DEST_ACC = 1'h0;
	localparam logic DEST_FILE = 1'h1;

	// Reset values
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] ICR_RST = 8'h00;
	localparam logic CARRY_RST = 1'h0;

	// Cycle counts per instruction
	localparam int CYC_SINGLE = 1;
	localparam int CYC_RETURN = 2;

endpackage

// >>> verilog/rroe_rotate.sv
`timescale 1ns/1ns
`default_nettype none

module rroe_rotate import rroe_pkg::*; #(
	parameter int WIDTH = DATA_WIDTH
) (
	// Operand and carry in
	input wire logic [WIDTH-1:0] operand,
	input wire logic carry_in,
	// Result and carry out
	output logic [WIDTH-1:0] result,
	output logic carry_out
);

	// Old MSB leaves into carry, old carry enters at bit 0
	assign result = {operand[WIDTH-2:0], carry_in};
	assign carry_out = operand[WIDTH-1];

endmodule

`default_nettype wire

// >>> verilog/rroe_exec.sv
// Summary of operation
// - Interrupt return pops stack, sets enable, two cycles
// - Literal return loads accumulator and PC, two cycles
// - Subroutine exit pops stack into PC, two cycles
// - Rotate file register left through carry only
// - Destination bit picks accumulator or file register
`timescale 1ns/1ns
`default_nettype none

module rroe_exec import rroe_pkg::*; #(
	parameter int PCW = PC_WIDTH,
	parameter int DW = DATA_WIDTH,
	parameter int AW = FADDR_WIDTH
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic ARST_N,
	// Instruction issue
	input wire logic INSTR_VALID,
	input wire rroe_op_t INSTR_OP,
	input wire logic [DW-1:0] INSTR_LITERAL,
	input wire logic [AW-1:0] INSTR_FADDR,
	input wire logic INSTR_DEST,
	output logic INSTR_READY,
	output logic INSTR_DONE,
	// Return stack
	input wire logic [PCW-1:0] STACK_TOP,
	output logic STACK_POP,
	// File register access
	input wire logic [DW-1:0] FILE_RDATA,
	output logic FILE_WE,
	output logic [AW-1:0] FILE_WADDR,
	output logic [DW-1:0] FILE_WDATA,
	// Architectural state
	output logic [PCW-1:0] PC_OUT,
	output logic [DW-1:0] ACC_OUT,
	output logic CARRY_OUT,
	output logic [7:0] ICR_OUT
);

	typedef struct packed {
		rroe_state_t state;
		logic [PCW-1:0] pc;
		logic [DW-1:0] acc;
		logic carry;
		logic [7:0] icr;
		logic ready;
		logic done;
		logic pop;
		logic fwe;
		logic [AW-1:0] fwaddr;
		logic [DW-1:0] fwdata;
	} rroe_regs_t;

	rroe_regs_t q_ff;
	rroe_regs_t nxt_q;
	logic take;
	logic [DW-1:0] rot_result;
	logic rot_carry;

	assign take = INSTR_VALID && q_ff.ready;

	// Rotate datapath works on the addressed register's current value
	rroe_rotate #(
		.WIDTH(DW)
	) u_rotate (
		.operand(FILE_RDATA),
		.carry_in(q_ff.carry),
		.result(rot_result),
		.carry_out(rot_carry)
	);

	// Next-state logic; strobes default low so they last one cycle
	always_comb begin
		nxt_q = q_ff;
		nxt_q.done = 1'h0;
		nxt_q.pop = 1'h0;
		nxt_q.fwe = 1'h0;
		case (q_ff.state)
			ST_READY: begin
				if (take) begin
					case (INSTR_OP)
						idle_op: begin
							nxt_q.pc = q_ff.pc + PCW'(1);
							nxt_q.done = 1'h1;
						end
						return_from_interrupt_op: begin
							nxt_q.pc = STACK_TOP;
							nxt_q.pop = 1'h1;
							nxt_q.icr[GIE_BIT] = 1'h1;
							nxt_q.ready = 1'h0;
							nxt_q.state = ST_SECOND;
						end
						return_with_literal_op: begin
							nxt_q.acc = INSTR_LITERAL;
							nxt_q.pc = STACK_TOP;
							nxt_q.pop = 1'h1;
							nxt_q.ready = 1'h0;
							nxt_q.state = ST_SECOND;
						end
						subroutine_exit_op: begin
							nxt_q.pc = STACK_TOP;
							nxt_q.pop = 1'h1;
							nxt_q.ready = 1'h0;
							nxt_q.state = ST_SECOND;
						end
						rotate_left_carry_op: begin
							nxt_q.carry = rot_carry;
							nxt_q.pc = q_ff.pc + PCW'(1);
							nxt_q.done = 1'h1;
							if (INSTR_DEST == DEST_FILE) begin
								nxt_q.fwe = 1'h1;
								nxt_q.fwaddr = INSTR_FADDR;
								nxt_q.fwdata = rot_result;
							end else begin
								nxt_q.acc = rot_result;
							end
						end
						default: begin
							// Unknown codes behave as idle so the PC never stalls
							nxt_q.pc = q_ff.pc + PCW'(1);
							nxt_q.done = 1'h1;
						end
					endcase
				end
			end
			ST_SECOND: begin
				// Flushed fetch slot of a return; nothing else changes
				nxt_q.ready = 1'h1;
				nxt_q.done = 1'h1;
				nxt_q.state = ST_READY;
			end
			default: begin
				nxt_q.state = ST_READY;
				nxt_q.ready = 1'h1;
			end
		endcase
	end

	// State register
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			q_ff <= '{state: ST_READY, pc: '0, acc: ACC_RST,
				carry: CARRY_RST, icr: ICR_RST, ready: 1'h1,
				done: 1'h0, pop: 1'h0, fwe: 1'h0, fwaddr: '0,
				fwdata: '0};
		end else begin
			q_ff <= nxt_q;
		end
	end

	// Outputs straight from flip-flops
	assign INSTR_READY = q_ff.ready;
	assign INSTR_DONE = q_ff.done;
	assign STACK_POP = q_ff.pop;
	assign FILE_WE = q_ff.fwe;
	assign FILE_WADDR = q_ff.fwaddr;
	assign FILE_WDATA = q_ff.fwdata;
	assign PC_OUT = q_ff.pc;
	assign ACC_OUT = q_ff.acc;
	assign CARRY_OUT = q_ff.carry;
	assign ICR_OUT = q_ff.icr;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);

	// Two-cycle return: busy one cycle, then done with ready back
	sequence s_return_tail;
		(!q_ff.ready && !q_ff.done) ##1 (q_ff.ready && q_ff.done);
	endsequence

	sequence s_flags_hold;
		$stable(q_ff.carry) && !q_ff.fwe;
	endsequence

	a_rfi_gie_set: assert property (
		take && INSTR_OP == return_from_interrupt_op
		|=> (q_ff.icr[GIE_BIT] && q_ff.pop
		&& q_ff.pc == $past(STACK_TOP)) and s_flags_hold)
		else $error("interrupt return did not restore PC and enable");

	a_rfi_two_cycles: assert property (
		take && INSTR_OP == return_from_interrupt_op |=> s_return_tail)
		else $error("interrupt return not two cycles");

	a_rwl_acc_load: assert property (
		take && INSTR_OP == return_with_literal_op
		|=> ((q_ff.acc == $past(INSTR_LITERAL)
		&& q_ff.pc == $past(STACK_TOP)) and s_flags_hold)
		##0 s_return_tail)
		else $error("literal return wrong");

	a_sub_exit_pop: assert property (
		take && INSTR_OP == subroutine_exit_op
		|=> ((q_ff.pop && q_ff.pc == $past(STACK_TOP)
		&& $stable(q_ff.acc)) and s_flags_hold) ##0 s_return_tail)
		else $error("subroutine exit wrong");

	a_rot_carry_out: assert property (
		take && INSTR_OP == rotate_left_carry_op
		|=> q_ff.carry == $past(FILE_RDATA[DW-1])
		&& $stable(q_ff.icr) && q_ff.done)
		else $error("rotate carry wrong");

	a_rot_to_acc: assert property (
		take && INSTR_OP == rotate_left_carry_op && INSTR_DEST == DEST_ACC
		|=> !q_ff.fwe && q_ff.acc ==
		{$past(FILE_RDATA[DW-2:0]), $past(q_ff.carry)})
		else $error("rotate to accumulator wrong");

	a_rot_to_file: assert property (
		take && INSTR_OP == rotate_left_carry_op && INSTR_DEST == DEST_FILE
		|=> q_ff.fwe && $stable(q_ff.acc)
		&& q_ff.fwaddr == $past(INSTR_FADDR)
		&& q_ff.fwdata == {$past(FILE_RDATA[DW-2:0]), $past(q_ff.carry)}
		// Strobe lasts one cycle unless another file rotate follows
		##1 q_ff.fwe == $past(take && INSTR_OP == rotate_left_carry_op
		&& INSTR_DEST == DEST_FILE))
		else $error("rotate to file register wrong");

	a_idle_pc_step: assert property (
		take && INSTR_OP == idle_op
		|=> (q_ff.pc == $past(q_ff.pc) + PCW'(1) && $stable(q_ff.acc)
		&& $stable(q_ff.icr) && !q_ff.pop
		&& q_ff.done && q_ff.ready) and s_flags_hold)
		else $error("idle op changed state");

endmodule

`default_nettype wire

// >>> verification/rroe_exec_tb.sv
`timescale 1ns/1ns
`default_nettype none

// Counts every comparison; case equality so an unknown never matches
`define CHK(got, exp) begin \
	compares++; \
	if ((got) !== (exp)) begin \
		fail_count++; \
		$display("ERROR %0t: got %h exp %h", $time, got, exp); \
	end \
end

module rroe_exec_tb import rroe_pkg::*;;
	logic clk = 1'h0;
	logic arst_n = 1'h0;
	logic valid = 1'h0;
	rroe_op_t op = idle_op;
	logic [7:0] lit = 8'h00;
	logic [6:0] faddr = 7'h00;
	logic dest = 1'h0;
	logic [12:0] stack_top = 13'h0000;
	logic [7:0] rdata = 8'h00;
	logic ready, done, pop, we, carry;
	logic [6:0] waddr;
	logic [7:0] wdata, acc, icr;
	logic [12:0] pc;
	int fail_count = 0;
	int compares = 0;

	rroe_exec dut (.REF_CLK(clk), .ARST_N(arst_n), .INSTR_VALID(valid),
		.INSTR_OP(op), .INSTR_LITERAL(lit), .INSTR_FADDR(faddr),
		.INSTR_DEST(dest), .INSTR_READY(ready), .INSTR_DONE(done),
		.STACK_TOP(stack_top), .STACK_POP(pop), .FILE_RDATA(rdata),
		.FILE_WE(we), .FILE_WADDR(waddr), .FILE_WDATA(wdata),
		.PC_OUT(pc), .ACC_OUT(acc), .CARRY_OUT(carry), .ICR_OUT(icr));

	// Clock at 20 MHz
	initial begin
		forever #25 clk = ~clk;
	end

	// Inputs move a fixed 1 ns after the edge, away from sampling
	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	task automatic finish_test();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Back-to-back idles only move the PC
	task automatic idle_pair();
		valid = 1'h1;
		op = idle_op;
		tick();
		`CHK({pc, done, acc, carry, icr}, {13'h0001, 1'h1, 8'h00, 1'h0, 8'h00})
		tick();
		`CHK({pc, done, we, pop}, {13'h0002, 1'h1, 1'h0, 1'h0})
	endtask

	// Rotate to accumulator, then straight into a file write-back
	task automatic rotate_pair();
		op = rotate_left_carry_op;
		rdata = 8'he6;
		faddr = 7'h05;
		tick();
		`CHK({acc, carry, we, pc, done}, {8'hcc, 1'h1, 1'h0, 13'h0003, 1'h1})
		rdata = 8'h81;
		faddr = 7'h7f;
		dest = 1'h1;
		tick();
		`CHK({we, waddr, wdata, carry}, {1'h1, 7'h7f, 8'h03, 1'h1})
		`CHK({acc, icr, pc}, {8'hcc, 8'h00, 13'h0004})
		valid = 1'h0;
		tick();
		`CHK({we, done, pc, waddr, wdata}, {1'h0, 1'h0, 13'h0004, 7'h7f, 8'h03})
	endtask

	// Two-cycle return; an idle held in the dead slot must be refused
	task automatic do_return(input rroe_op_t o, input logic [12:0] t,
		input logic [7:0] eacc, input logic [7:0] eicr);
		valid = 1'h1;
		op = o;
		stack_top = t;
		lit = 8'hff;
		tick();
		op = idle_op;
		stack_top = ~t;
		`CHK({pc, pop, ready, done}, {t, 1'h1, 1'h0, 1'h0})
		`CHK({acc, icr, carry}, {eacc, eicr, 1'h1})
		tick();
		`CHK({pc, pop, ready, done}, {t, 1'h0, 1'h1, 1'h1})
		valid = 1'h0;
		tick();
	endtask

	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		#1;
		arst_n = 1'h1;
		`CHK({ready, pc, acc, icr, carry, we}, {1'h1, 13'h0, 8'h0, 8'h0, 1'h0, 1'h0})
		idle_pair();
		rotate_pair();
		do_return(subroutine_exit_op, 13'h1fff, 8'hcc, 8'h00);
		do_return(return_from_interrupt_op, 13'h0abc, 8'hcc, 8'h80);
		do_return(return_with_literal_op, 13'h0000, 8'hff, 8'h80);
		finish_test();
	end

	// Watchdog at 400 cycles, well beyond the 18 cycles the tests need
	initial begin
		#(400 * 50);
		fail_count++;
		finish_test();
	end
endmodule

`default_nettype wire
